// file: dv/csi_sink_model.sv
// downstream packet builder model: accepts beats, prompt or stalling
// assumes the bench seeds the random generator
`timescale 1ns/100ps
module csi_sink_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic csi_ready
);
  // stalls one cycle in three on average so held beats get exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csi_ready <= 1'b0;
    end else begin
      csi_ready <= !slow || ($urandom % 3 != 0);
    end
  end
endmodule : csi_sink_model

// file: dv/pattern_frame_gen_assertions.sv
// port checker for the pattern frame generator
// bound into every pattern_frame_gen, sees its ports only
`timescale 1ns/100ps
module pattern_frame_gen_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic csi_valid,
  input wire logic csi_ready,
  input wire pattern_gen_pkg::csi_beat_s csi_beat
);
  import pattern_gen_pkg::*;
  logic [7:0] shadow [12:18];
  logic took_last;
  wire logic access = psel && penable;
  wire logic [5:0] idx = paddr[7:2];
  wire logic in_cfg = idx >= 6'h0C && idx <= 6'h12 && paddr[1:0] == 2'h0;
  // expected timing and pattern bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 12; i <= 18; i++) begin
        shadow[i] <= CFG_RESET[i];
      end
    end else if (access && pwrite && pstrb[0] && in_cfg) begin
      shadow[idx] <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      took_last <= 1'b0;
    end else begin
      took_last <= csi_valid && csi_ready && csi_beat.last;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (access |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (access && idx > 6'h12 |-> pslverr)
    else $error("unmapped access not refused");
  cfg_no_err_a: assert property (access && in_cfg |-> !pslverr)
    else $error("mapped register refused");
  reg_readback_a: assert property (access && !pwrite && in_cfg |-> prdata[7:0] == shadow[idx])
    else $error("register read wrong");
  read_pad_a: assert property (access && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  beat_hold_a: assert property (csi_valid && !csi_ready |=> csi_valid && $stable(csi_beat))
    else $error("beat moved while stalled");
  marker_beat_a: assert property (csi_valid && csi_beat.kind != PKT_LINE |-> csi_beat.first && csi_beat.last)
    else $error("frame marker not single beat");
  packet_start_a: assert property ($rose(csi_valid) |-> csi_beat.first)
    else $error("packet opens without first");
  packet_whole_a: assert property ($fell(csi_valid) |-> took_last)
    else $error("valid dropped mid packet");
endmodule : pattern_frame_gen_assertions

bind pattern_frame_gen pattern_frame_gen_assertions chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .csi_valid(csi_valid), .csi_ready(csi_ready), .csi_beat(csi_beat)
);

// file: dv/test_test_pattern_frame_timing.sv
// self-checking bench for the pattern frame generator
// APB master tasks, beat monitor and a queue model of one frame
`timescale 1ns/100ps
module test_test_pattern_frame_timing;
  import pattern_gen_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, slow, vprev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, csi_valid, csi_ready;
  csi_beat_s csi_beat;
  csi_beat_s beats [$];
  int rises [$];
  int cyc, num_errors, checks_done;
  logic [7:0] col [3];
  int unit_ps [4] = '{10000, 13330, 20000, 10000};
  // short frame: 7-byte lines, bar width 2, two active lines, period 0x0030, porches 2 and 1
  logic [7:0] cfg [4:15] = '{8'h00, 8'h07, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h30,
    8'h02, 8'h01};

  pattern_frame_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .csi_valid(csi_valid), .csi_ready(csi_ready), .csi_beat(csi_beat));
  csi_sink_model sink (.pclk(pclk), .presetn(presetn), .slow(slow), .csi_ready(csi_ready));

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    vprev <= csi_valid;
    if (csi_valid === 1'b1 && csi_ready === 1'b1) begin
      beats.push_back(csi_beat);
    end
    if (csi_valid === 1'b1 && vprev !== 1'b1) begin
      rises.push_back(cyc);
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [31:0] q,
      output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask : wr

  task automatic rd(input logic [5:0] i, input logic [7:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, i, 8'h00, q, e);
    check("read data", q, {24'h0, x});
    check("read error", {31'h0, e}, {31'h0, xe});
  endtask : rd

  // rate 1 slots are not whole cycles, so allow under one cycle of error
  task automatic gap(input int g, input int k, input int r, input int p);
    longint e;
    e = longint'(k) * p * unit_ps[r] - longint'(g) * 20000;
    check("line gap", {31'h0, e < 20000 && e > -20000}, 32'h1);
  endtask : gap

  // frame of 7-byte lines, bar width 2, two active lines
  function automatic csi_beat_s model(int b, logic fixed);
    csi_beat_s m;
    int i;
    i = (b + 6) % 7;
    m.kind = b == 0 ? PKT_FRAME_START : b == 15 ? PKT_FRAME_END : PKT_LINE;
    m.first = m.kind != PKT_LINE || i == 0;
    m.last = m.kind != PKT_LINE || i == 6;
    m.data = m.kind != PKT_LINE ? 8'h00 : col[fixed ? i % 3 : (i > 3 ? 2 : i / 2)];
    return m;
  endfunction : model

  initial begin
    logic [7:0] v [12:18];
    int n;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    slow = 1'b0;
    vprev = 1'b0;
    cyc = 0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(95));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 12; i <= 18; i++) begin
      rd(i[5:0], CFG_RESET[i], 1'b0);
    end
    for (int i = 12; i <= 18; i++) begin
      v[i] = 8'($urandom);
      wr(i[5:0], v[i]);
      rd(i[5:0], v[i], 1'b0);
    end
    rd(6'h13, 8'h00, 1'b1);
    rd(6'h01, 8'h00, 1'b0);
    // a write without its low byte strobe must leave the register alone
    pstrb <= 4'h0;
    wr(6'h10, ~v[16]);
    pstrb <= 4'hF;
    rd(6'h10, v[16], 1'b0);
    for (int i = 4; i <= 15; i++) begin
      wr(i[5:0], cfg[i]);
    end
    col = '{v[16], v[17], v[18]};
    for (int r = 0; r < 4; r++) begin
      slow <= (r == 1);
      beats.delete();
      rises.delete();
      wr(6'h01, {4'h0, r[1:0], r[0], 1'b1});
      rd(6'h01, {4'h0, r[1:0], r[0], 1'b1}, 1'b0);
      n = 0;
      while (beats.size() < 16 && n < 5000) begin
        @(posedge pclk);
        n++;
      end
      check("packet count", rises.size(), 32'h4);
      wr(6'h01, 8'h00);
      if (n >= 5000) begin
        num_errors++;
        finish_test();
      end
      for (int b = 0; b < 16; b++) begin
        check("beat", 32'(beats[b]), 32'(model(b, r[0])));
      end
      gap(rises[1] - rises[0], 3, r, 48);
      gap(rises[2] - rises[1], 1, r, 48);
      gap(rises[3] - rises[2], 2, r, 48);
    end
    // default period 0x0C67 at the 10 ns unit: one line of 31.75 us
    wr(6'h0C, CFG_RESET[12]);
    wr(6'h0D, CFG_RESET[13]);
    wr(6'h0E, 8'h00);
    rises.delete();
    wr(6'h01, 8'h01);
    n = 0;
    while (rises.size() < 2 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      finish_test();
    end
    gap(rises[1] - rises[0], 1, 0, 3175);
    finish_test();
  end
endmodule : test_test_pattern_frame_timing

// file: src/line_timer.sv
// line timer: one pulse per programmed line period
// assumes period and rate come from registers on the same clock
`timescale 1ns/100ps
module line_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [15:0] period,
  input wire pattern_gen_pkg::lane_rate_e rate,
  output logic line_tick
);
  import pattern_gen_pkg::*;

  logic [31:0] elapsed;
  logic [14:0] unit_ps;
  logic [31:0] target;
  logic [31:0] next_elapsed;
  logic [31:0] remainder;
  logic reached;

  // unknown rate code falls back to the 10 ns unit
  assign unit_ps = (rate == RATE_1200) ? UNIT_1200_PS :
                   (rate == RATE_400) ? UNIT_400_PS :
                   UNIT_800_PS;
  assign target = 32'(period) * 32'(unit_ps);
  assign next_elapsed = elapsed + 32'(CLK_PERIOD_PS);
  assign reached = next_elapsed >= target;
  assign remainder = next_elapsed - target;

  // carrying the remainder keeps the average period exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 32'h0;
      line_tick <= 1'b0;
    end else if (!run) begin
      elapsed <= 32'h0;
      line_tick <= 1'b0;
    end else if (reached) begin
      elapsed <= (remainder >= target) ? 32'h0 : remainder;
      line_tick <= 1'b1;
    end else begin
      elapsed <= next_elapsed;
      line_tick <= 1'b0;
    end
  end

endmodule : line_timer

// file: src/pattern_byte_source.sv
// pattern byte source: colour bars or repeating fixed bytes
// assumes start and advance are single-cycle strobes from the framer
`timescale 1ns/100ps
module pattern_byte_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic advance,
  input wire pattern_gen_pkg::pattern_cfg_s cfg,
  output logic [7:0] data
);
  import pattern_gen_pkg::*;

  logic [15:0] bar_pos;
  logic [1:0] bar_idx;
  logic [1:0] fix_idx;
  logic bar_end;
  logic [15:0] next_bar_pos;
  logic [1:0] next_bar_idx;
  logic [1:0] next_fix_idx;
  logic [1:0] sel;

  assign bar_end = ({1'b0, bar_pos} + 17'h1) >= {1'b0, cfg.bar_bytes};
  // the last bar never ends; it runs out with the line
  assign next_bar_idx = (bar_idx != LAST_BAR && bar_end) ? bar_idx + 2'h1 : bar_idx;
  assign next_bar_pos = (bar_idx == LAST_BAR) ? bar_pos :
                        bar_end ? 16'h0 : bar_pos + 16'h1;
  assign next_fix_idx = (fix_idx == LAST_BAR) ? 2'h0 : fix_idx + 2'h1;
  assign sel = cfg.fixed_mode ? next_fix_idx : next_bar_idx;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bar_pos <= 16'h0;
      bar_idx <= 2'h0;
      fix_idx <= 2'h0;
      data <= 8'h00;
    end else if (start) begin
      bar_pos <= 16'h0;
      bar_idx <= 2'h0;
      fix_idx <= 2'h0;
      data <= cfg.colour[0];
    end else if (advance) begin
      bar_pos <= next_bar_pos;
      bar_idx <= next_bar_idx;
      fix_idx <= next_fix_idx;
      data <= cfg.colour[sel];
    end
  end

endmodule : pattern_byte_source

// file: src/pattern_frame_gen.sv
// test pattern frame generator with APB register file
// assumes a CSI-2 packet builder downstream that takes one beat per valid&ready
// Function
// - low line period byte is read-write and forms the sixteen-bit period with the high byte
// - at 800 Mbps or 1.6 Gbps each period unit is 10 ns
// - at 1.2 Gbps each period unit is 13.33 ns
// - at 400 Mbps each period unit is 20 ns
// - low line period byte resets to 0x67
// - back porch blank lines follow frame start; reset 0x21
// - front porch blank lines precede frame end
// - colour bar N sends pattern byte N
// - fixed pattern repeats pattern bytes zero, one, two
// - pattern bytes reset to 0xAA, 0x33, 0xF0
// - high line period byte is read-write, reset 0x0C
// - bars span bar width; last bar takes the rest of the line
// - active and total lines per frame are sixteen-bit counts
// - active line length is a sixteen-bit byte count, default 1920
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module pattern_frame_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pattern_gen_pkg::ADDR_W-1:0] paddr,
  input wire logic [pattern_gen_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pattern_gen_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic csi_valid,
  input wire logic csi_ready,
  output pattern_gen_pkg::csi_beat_s csi_beat
);
  import pattern_gen_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME_START,
    ST_LINE,
    ST_FRAME_END
  } send_state_e;

  // bus decode
  logic [7:0] reg_index;
  logic aligned;
  logic hit_cfg;
  logic hit_ctrl;
  logic hit_stat;
  logic mapped;
  logic access;
  logic wr_byte;
  logic setup_read;
  logic [7:0] rd_byte;

  // register storage
  logic [7:0] cfg_q [CFG_FIRST:CFG_LAST];
  logic [CTRL_WIDTH-1:0] ctrl;
  logic overrun;
  logic [7:0] status;

  // fields
  logic enable;
  lane_rate_e rate;
  logic [15:0] line_period_count;
  logic [15:0] active_line_bytes;
  logic [15:0] active_lines_per_frame;
  logic [15:0] total_lines_per_frame;
  logic [7:0] vertical_back_porch;
  logic [7:0] vertical_front_porch;
  pattern_cfg_s pat_cfg;

  // framing
  logic line_tick;
  logic [LINE_W-1:0] line_no;
  logic [LINE_W-1:0] act_first;
  logic [LINE_W-1:0] act_last;
  logic [LINE_W-1:0] fe_slot;
  logic [LINE_W-1:0] frame_len;
  logic [LINE_W-1:0] line_inc;
  logic [LINE_W-1:0] next_line_no;
  logic in_active;
  logic want_fs;
  logic want_line;
  logic want_fe;
  logic sender_idle;
  logic launch_fs;
  logic launch_line;
  logic launch_fe;
  logic overrun_set;

  // sender
  send_state_e state;
  send_state_e next_state;
  logic [15:0] byte_cnt;
  logic beat_taken;
  logic line_last;
  logic gen_start;
  logic gen_advance;
  logic [7:0] gen_data;

  assign reg_index = {2'b00, paddr[ADDR_W-1:2]};
  assign aligned = paddr[1:0] == 2'b00;
  assign hit_cfg = reg_index >= 8'(CFG_FIRST) && reg_index <= 8'(CFG_LAST);
  assign hit_ctrl = reg_index == IDX_CONTROL;
  assign hit_stat = reg_index == IDX_STATUS;
  assign mapped = aligned && (hit_cfg || hit_ctrl || hit_stat);
  assign access = psel && penable;
  assign wr_byte = access && pwrite && pstrb[0] && mapped;
  assign setup_read = psel && !penable && !pwrite;

  // zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // one byte register per configuration index
  generate
    for (genvar i = CFG_FIRST; i <= CFG_LAST; i++) begin : g_cfg
      logic [7:0] value;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          value <= CFG_RESET[i];
        end else if (wr_byte && reg_index == 8'(i)) begin
          value <= pwdata[7:0];
        end
      end
      assign cfg_q[i] = value;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET[CTRL_WIDTH-1:0];
    end else if (wr_byte && hit_ctrl) begin
      ctrl <= pwdata[CTRL_WIDTH-1:0];
    end
  end

  // sticky overrun, write one to clear; a new overrun wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (overrun_set) begin
      overrun <= 1'b1;
    end else if (wr_byte && hit_stat && pwdata[STAT_OVERRUN_BIT]) begin
      overrun <= 1'b0;
    end
  end

  assign status = {5'h00, overrun, in_active, enable};

  assign rd_byte = !mapped ? 8'h00 :
                   hit_ctrl ? {{(8 - CTRL_WIDTH){1'b0}}, ctrl} :
                   hit_stat ? status :
                   cfg_q[reg_index];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_read) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // fields
  assign enable = ctrl[CTRL_ENABLE_BIT];
  assign rate = lane_rate_e'(ctrl[CTRL_RATE_LSB +: 2]);
  assign line_period_count = {cfg_q[IDX_LINE_PERIOD_HIGH], cfg_q[IDX_LINE_PERIOD_LOW]};
  assign active_line_bytes = {cfg_q[IDX_LINE_SIZE_HIGH], cfg_q[IDX_LINE_SIZE_LOW]};
  assign active_lines_per_frame = {cfg_q[IDX_ACT_LPF_HIGH], cfg_q[IDX_ACT_LPF_LOW]};
  assign total_lines_per_frame = {cfg_q[IDX_TOT_LPF_HIGH], cfg_q[IDX_TOT_LPF_LOW]};
  assign vertical_back_porch = cfg_q[IDX_VERTICAL_BACK_PORCH];
  assign vertical_front_porch = cfg_q[IDX_VERTICAL_FRONT_PORCH];
  assign pat_cfg.fixed_mode = ctrl[CTRL_FIXED_BIT];
  assign pat_cfg.bar_bytes = {cfg_q[IDX_BAR_SIZE_HIGH], cfg_q[IDX_BAR_SIZE_LOW]};
  assign pat_cfg.colour = {cfg_q[IDX_PATTERN_BYTE_TWO], cfg_q[IDX_PATTERN_BYTE_ONE],
                           cfg_q[IDX_PATTERN_BYTE_ZERO]};

  line_timer u_line_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(enable),
    .period(line_period_count),
    .rate(rate),
    .line_tick(line_tick)
  );

  // slot 0 carries frame start, then back porch, active, front porch, frame end
  assign act_first = LINE_W'(vertical_back_porch) + 18'h1;
  assign act_last = LINE_W'(vertical_back_porch) + LINE_W'(active_lines_per_frame);
  assign fe_slot = act_last + LINE_W'(vertical_front_porch) + 18'h1;
  // total may not cut a frame short
  assign frame_len = (LINE_W'(total_lines_per_frame) > fe_slot) ?
                     LINE_W'(total_lines_per_frame) : fe_slot + 18'h1;
  assign line_inc = line_no + 18'h1;
  assign next_line_no = (line_inc >= frame_len) ? 18'h0 : line_inc;

  assign in_active = enable && line_no >= act_first && line_no <= act_last
                     && active_lines_per_frame != 16'h0;
  assign want_fs = line_no == 18'h0;
  // empty lines would carry no bytes, so none is started
  assign want_line = in_active && active_line_bytes != 16'h0;
  assign want_fe = line_no == fe_slot;
  assign sender_idle = state == ST_IDLE;

  // porch slots launch nothing
  assign launch_fs = line_tick && sender_idle && want_fs;
  assign launch_line = line_tick && sender_idle && want_line;
  assign launch_fe = line_tick && sender_idle && want_fe;
  // a line that is still sending when the next starts is cut off by nothing
  assign overrun_set = line_tick && !sender_idle;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_no <= '0;
    end else if (!enable) begin
      line_no <= '0;
    end else if (line_tick) begin
      line_no <= next_line_no;
    end
  end

  // sender
  assign beat_taken = csi_valid && csi_ready;
  assign line_last = byte_cnt == active_line_bytes - 16'h1;
  assign gen_start = launch_line;
  assign gen_advance = state == ST_LINE && beat_taken && !line_last;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (launch_fs) begin
          next_state = ST_FRAME_START;
        end else if (launch_line) begin
          next_state = ST_LINE;
        end else if (launch_fe) begin
          next_state = ST_FRAME_END;
        end
      end
      ST_FRAME_START: begin
        if (beat_taken) begin
          next_state = ST_IDLE;
        end
      end
      ST_LINE: begin
        if (beat_taken && line_last) begin
          next_state = ST_IDLE;
        end
      end
      ST_FRAME_END: begin
        if (beat_taken) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // disabling drops any packet in flight at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (!enable) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt <= 16'h0;
    end else if (gen_start) begin
      byte_cnt <= 16'h0;
    end else if (gen_advance) begin
      byte_cnt <= byte_cnt + 16'h1;
    end
  end

  pattern_byte_source u_pattern_byte_source (
    .pclk(pclk),
    .presetn(presetn),
    .start(gen_start),
    .advance(gen_advance),
    .cfg(pat_cfg),
    .data(gen_data)
  );

  assign csi_valid = !sender_idle;
  assign csi_beat.kind = (state == ST_FRAME_START) ? PKT_FRAME_START :
                         (state == ST_FRAME_END) ? PKT_FRAME_END : PKT_LINE;
  assign csi_beat.first = (state != ST_LINE) || byte_cnt == 16'h0;
  assign csi_beat.last = (state != ST_LINE) || line_last;
  assign csi_beat.data = (state == ST_LINE) ? gen_data : 8'h00;

endmodule : pattern_frame_gen

// file: src/pattern_gen_pkg.sv
// constants, types and register map of the test pattern frame generator
// assumes a 50 MHz pclk and an APB slave with word-aligned byte registers
package pattern_gen_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_LINE_SIZE_HIGH = 8'h04;
  localparam logic [7:0] IDX_LINE_SIZE_LOW = 8'h05;
  localparam logic [7:0] IDX_BAR_SIZE_HIGH = 8'h06;
  localparam logic [7:0] IDX_BAR_SIZE_LOW = 8'h07;
  localparam logic [7:0] IDX_ACT_LPF_HIGH = 8'h08;
  localparam logic [7:0] IDX_ACT_LPF_LOW = 8'h09;
  localparam logic [7:0] IDX_TOT_LPF_HIGH = 8'h0A;
  localparam logic [7:0] IDX_TOT_LPF_LOW = 8'h0B;
  localparam logic [7:0] IDX_LINE_PERIOD_HIGH = 8'h0C;
  localparam logic [7:0] IDX_LINE_PERIOD_LOW = 8'h0D;
  localparam logic [7:0] IDX_VERTICAL_BACK_PORCH = 8'h0E;
  localparam logic [7:0] IDX_VERTICAL_FRONT_PORCH = 8'h0F;
  localparam logic [7:0] IDX_PATTERN_BYTE_ZERO = 8'h10;
  localparam logic [7:0] IDX_PATTERN_BYTE_ONE = 8'h11;
  localparam logic [7:0] IDX_PATTERN_BYTE_TWO = 8'h12;
  localparam int CFG_FIRST = 4;
  localparam int CFG_LAST = 18;

  // reset values, first entry at CFG_FIRST
  localparam logic [7:0] VFP_RESET = 8'h0A;
  localparam logic [7:0] CFG_RESET [CFG_FIRST:CFG_LAST] = '{
    8'h07, 8'h80,            // active line bytes, 1920
    8'h00, 8'hF0,            // bar width bytes
    8'h01, 8'hE0,            // active lines per frame, 480
    8'h02, 8'h0D,            // total lines per frame
    8'h0C, 8'h67,            // line period count
    8'h21, VFP_RESET,        // porches
    8'hAA, 8'h33, 8'hF0      // pattern bytes
  };

  // control and status fields
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FIXED_BIT = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_WIDTH = 4;
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;

  // line timer works in picoseconds so 13.33 ns needs no rounding
  localparam int CLK_PERIOD_PS = 20000;
  localparam logic [14:0] UNIT_800_PS = 15'd10000;
  localparam logic [14:0] UNIT_1200_PS = 15'd13330;
  localparam logic [14:0] UNIT_400_PS = 15'd20000;

  localparam int LINE_W = 18;
  localparam logic [1:0] LAST_BAR = 2'h2;

  typedef enum logic [1:0] {
    RATE_800_1600 = 2'h0,
    RATE_1200 = 2'h1,
    RATE_400 = 2'h2
  } lane_rate_e;

  typedef enum logic [1:0] {
    PKT_FRAME_START = 2'h0,
    PKT_LINE = 2'h1,
    PKT_FRAME_END = 2'h2
  } packet_kind_e;

  typedef struct packed {
    packet_kind_e kind;
    logic first;
    logic last;
    logic [7:0] data;
  } csi_beat_s;

  typedef struct packed {
    logic fixed_mode;
    logic [15:0] bar_bytes;
    logic [2:0][7:0] colour;
  } pattern_cfg_s;

endpackage : pattern_gen_pkg
